// >>> inc/aux_pin_cfg.svh
`ifndef AUX_PIN_CFG_SVH
`define AUX_PIN_CFG_SVH

// ============================================================
// Register offsets
// ============================================================
`define PIN_FUNCTION_CONFIG_ADDR 8'h33
`define SECONDARY_STATUS_ADDR    8'h40
`define SECONDARY_FAULT_ADDR     8'h41

// ============================================================
// Function field encodings
// ============================================================
`define FN_IN_HIGH   2'h3
`define FN_IN_LOW    2'h2
`define FN_OUT_ALT   2'h1
`define FN_SPECIAL   2'h0

// ============================================================
// Field positions and reset values
// ============================================================
`define CFG_PIN1_MSB     7
`define CFG_PIN1_LSB     6
`define CFG_PIN2_MSB     5
`define CFG_PIN2_LSB     4
`define CFG_PIN3_MSB     3
`define CFG_PIN3_LSB     2
`define CFG_PIN2_OUT_BIT 1
`define CFG_WRITE_MASK   8'hfe
`define CFG_RESET        8'h00
`define STAT_PIN1_BIT    6
`define STAT_PIN2_BIT    5
`define STAT_PIN3_BIT    4
`define STAT_BUSY_BIT    3
`define STAT_ENERGY_BIT  2
`define STAT_CHARGE_BIT  1
`define STAT_TIMER_BIT   0
`define FLT_RSVD_BIT     7
`define FLT_WAKE_BIT     3
`define FLT_LATCH_MASK   7'h7f
`define FLT_RESET        7'h00
`define BYTE_ZERO        8'h00

`endif

// >>> inc/aux_pin_pkg.sv
`default_nettype none
// ============================================================
// Shared types
// ============================================================
package aux_pin_pkg;

    // Accumulator overflow flags, one per accumulator.
    typedef struct packed {
        logic energy;
        logic charge;
        logic timer;
    } overflow_t;

    // Register access request from the serial engine.
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : aux_pin_pkg

`default_nettype wire

// >>> hdl/aux_pin_status_fault_regs.sv
// What this block does
// (R1) Pin one: input high/low, hi-z, pull low
// (R2) Pin two: inputs, bit-driven output, gate input
// (R3) Pin three: inputs, external-controlled output, alert
// (R4) Pin two output pulls low when bit set
// (R5) Status bits 6..4 show input active levels
// (R6) Gate mode: status bit 5 shows raw level
// (R7) Status bit 3 shows snapshot conversion busy
// (R8) Status bits 2..0 show accumulator overflows
// (R9) Fault bits 6..4 latch active pin inputs
// (R10) Fault bit 3 latches timeout wake-up, when enabled
// (R11) Fault bits 2..0 latch accumulator overflows
// (R12) Alert mode: pin three pulls low on alert
// (R13) Fault bits stay until host writes zero
// (R14) Reserved bits read zero; fault top reads one
`timescale 1ns/1ps
`default_nettype none
`include "aux_pin_cfg.svh"

module aux_pin_status_fault_regs #(
    parameter int NUM_PINS = 3
) (
    // Clock and reset.
    input  wire logic                    ref_clk_in,
    input  wire logic                    resetn_in,
    // Register access from the serial engine, same clock.
    input  wire aux_pin_pkg::reg_req_t   reg_req_in,
    output var  logic [7:0]              reg_rdata_out,
    // Auxiliary pins, open drain: level in, drive and enable out.
    input  wire logic [NUM_PINS-1:0]     aux_pin_in,
    output var  logic [NUM_PINS-1:0]     aux_pin_out,
    output var  logic [NUM_PINS-1:0]     aux_pin_oe_out,
    // Integration gate level for the accumulators.
    output var  logic                    integration_gate_out,
    // Events and levels from the rest of the device.
    input  wire logic                    snapshot_busy_in,
    input  wire aux_pin_pkg::overflow_t  overflow_in,
    input  wire logic                    stuck_bus_wake_in,
    input  wire logic                    wake_on_timeout_in,
    input  wire logic                    alert_generated_in,
    input  wire logic                    pin3_pulldown_in
);

    // ============================================================
    // Helpers
    // ============================================================

    // True when a pin in an input mode sits at its active level.
    function automatic logic pin_active(input logic [1:0] fn, input logic lvl);
        logic r;
        r = 1'b0;
        if (fn == `FN_IN_HIGH) begin
            r = lvl;
        end else if (fn == `FN_IN_LOW) begin
            r = ~lvl;
        end
        return r;
    endfunction : pin_active

    // ============================================================
    // Pin synchronisers
    // ============================================================
    logic [NUM_PINS-1:0] sync1_q;   // First stage, read only by the second.
    logic [NUM_PINS-1:0] sync2_q;   // Stable pin levels.

    // Pins are asynchronous to the core clock, so each passes two flops.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
            always_ff @(posedge ref_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= aux_pin_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // ============================================================
    // Register state
    // ============================================================
    logic [7:0] cfg_q,   cfg_d;     // Pin function configuration.
    logic [6:0] fault_q, fault_d;   // Latched fault bits.
    logic [7:0] status_q, status_d; // Live status snapshot.
    logic [7:0] rdata_q, rdata_d;   // Read data holding register.
    logic [NUM_PINS-1:0] oe_q, oe_d; // Pin pull-down enables.
    logic       gate_q, gate_d;     // Integration gate level.

    logic [1:0] fn1, fn2, fn3;      // Decoded function fields.
    logic       act1, act2, act3;   // Input-active indications.
    logic       wr_cfg, wr_fault, rd_any;

    // Field extraction and access decode.
    always_comb begin
        fn1      = cfg_q[`CFG_PIN1_MSB:`CFG_PIN1_LSB];
        fn2      = cfg_q[`CFG_PIN2_MSB:`CFG_PIN2_LSB];
        fn3      = cfg_q[`CFG_PIN3_MSB:`CFG_PIN3_LSB];
        act1     = pin_active(fn1, sync2_q[0]);
        act2     = pin_active(fn2, sync2_q[1]);
        act3     = pin_active(fn3, sync2_q[2]);
        wr_cfg   = reg_req_in.wr && (reg_req_in.addr == `PIN_FUNCTION_CONFIG_ADDR);
        wr_fault = reg_req_in.wr && (reg_req_in.addr == `SECONDARY_FAULT_ADDR);
        rd_any   = reg_req_in.rd;
    end

    // Next-value logic for configuration, status and pin drive.
    always_comb begin
        cfg_d = cfg_q;
        if (wr_cfg) begin
            // Reserved bit zero is never stored, so it reads back zero.
            cfg_d = reg_req_in.wdata & `CFG_WRITE_MASK; // (R14)
        end

        // Pin one: only the pull-low output code drives. (R1)
        oe_d[0] = (fn1 == `FN_SPECIAL);
        // Pin two: output mode pulls low when the control bit is one. (R2)
        oe_d[1] = (fn2 == `FN_OUT_ALT) && cfg_q[`CFG_PIN2_OUT_BIT]; // (R4)
        // Pin three: external control or alert, both open drain. (R3)
        unique case (fn3)
            `FN_OUT_ALT: oe_d[2] = pin3_pulldown_in;
            `FN_SPECIAL: oe_d[2] = alert_generated_in; // (R12)
            default:     oe_d[2] = 1'b0;
        endcase

        // The gate only counts while pin two is the gate input. (R2)
        gate_d = (fn2 == `FN_SPECIAL) ? sync2_q[1] : 1'b0;

        status_d = `BYTE_ZERO; // (R14)
        status_d[`STAT_PIN1_BIT] = act1; // (R5)
        // Gate mode reports the raw level rather than an active sense.
        status_d[`STAT_PIN2_BIT] = (fn2 == `FN_SPECIAL) ? sync2_q[1] : act2; // (R5) (R6)
        status_d[`STAT_PIN3_BIT] = act3; // (R5)
        status_d[`STAT_BUSY_BIT] = snapshot_busy_in; // (R7)
        status_d[`STAT_ENERGY_BIT] = overflow_in.energy; // (R8)
        status_d[`STAT_CHARGE_BIT] = overflow_in.charge; // (R8)
        status_d[`STAT_TIMER_BIT]  = overflow_in.timer;  // (R8)
    end

    // Next-value logic for the latched faults.
    always_comb begin
        logic [6:0] set_v;
        set_v = `FLT_RESET;
        set_v[`STAT_PIN1_BIT] = act1; // (R9)
        set_v[`STAT_PIN2_BIT] = act2; // (R9)
        set_v[`STAT_PIN3_BIT] = act3; // (R9)
        set_v[`FLT_WAKE_BIT]  = stuck_bus_wake_in && wake_on_timeout_in; // (R10)
        set_v[`STAT_ENERGY_BIT] = overflow_in.energy; // (R11)
        set_v[`STAT_CHARGE_BIT] = overflow_in.charge; // (R11)
        set_v[`STAT_TIMER_BIT]  = overflow_in.timer;  // (R11)
        fault_d = fault_q;
        if (wr_fault) begin
            // A zero clears; a one leaves the bit as it was. (R13)
            fault_d = fault_q & reg_req_in.wdata[6:0];
        end
        // A new event beats a clear in the same cycle, so none is lost.
        fault_d = (fault_d | set_v) & `FLT_LATCH_MASK; // (R9) (R10) (R11)
    end

    // Read mux; the holding register keeps its value between reads.
    always_comb begin
        rdata_d = rdata_q;
        if (rd_any) begin
            unique case (reg_req_in.addr)
                `PIN_FUNCTION_CONFIG_ADDR: rdata_d = cfg_q;
                `SECONDARY_STATUS_ADDR:    rdata_d = status_q;
                `SECONDARY_FAULT_ADDR:     rdata_d = {1'b1, fault_q}; // (R13) (R14)
                default:                   rdata_d = `BYTE_ZERO;
            endcase
        end
    end

    // All state registers except the pin synchronisers.
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_q    <= `CFG_RESET; // (R1)
            fault_q  <= `FLT_RESET;
            status_q <= `BYTE_ZERO; // (R7)
            rdata_q  <= `BYTE_ZERO;
            oe_q     <= '0;
            gate_q   <= 1'b0;
        end else begin
            cfg_q    <= cfg_d;
            fault_q  <= fault_d;
            status_q <= status_d;
            rdata_q  <= rdata_d;
            oe_q     <= oe_d;
            gate_q   <= gate_d;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    // Open drain: the data line is held low and only the enable moves.
    always_comb begin
        reg_rdata_out        = rdata_q;
        aux_pin_out          = '0;
        aux_pin_oe_out       = oe_q;
        integration_gate_out = gate_q;
    end

endmodule : aux_pin_status_fault_regs

`default_nettype wire

// >>> test/aux_pin_status_fault_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker for the pin and fault block
// ==========================================
module aux_regs_props #(
    parameter int NUM_PINS = 3
) (
    input wire logic                  ref_clk_in,
    input wire logic                  resetn_in,
    input wire aux_pin_pkg::reg_req_t reg_req_in,
    input wire logic [7:0]            reg_rdata_out,
    input wire logic [NUM_PINS-1:0]   aux_pin_out,
    input wire logic [NUM_PINS-1:0]   aux_pin_oe_out,
    input wire logic                  integration_gate_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // Configuration write strobe and the request address.
    logic cw;
    logic [7:0] a;
    assign cw = reg_req_in.wr && reg_req_in.addr == 8'h33;
    assign a  = reg_req_in.addr;
    // Pin drive and gate lag a configuration write by two edges: one edge
    // stores the field, the next registers the decoded drive.
    pin1_low_a: assert property (cw && reg_req_in.wdata[7:6] == 2'h0 |-> ##2 aux_pin_oe_out[0])
        else $error("pin one not pulled low");
    pin1_rel_a: assert property (cw && reg_req_in.wdata[7:6] != 2'h0 |-> ##2 !aux_pin_oe_out[0])
        else $error("pin one driven while not output low");
    pin2_out_a: assert property (cw && reg_req_in.wdata[5:4] == 2'h1 |-> ##2 aux_pin_oe_out[1] == $past(reg_req_in.wdata[1], 2))
        else $error("pin two drive differs from its output bit");
    pin2_rel_a: assert property (cw && reg_req_in.wdata[5:4] != 2'h1 |-> ##2 !aux_pin_oe_out[1])
        else $error("pin two driven outside output mode");
    gate_off_a: assert property (cw && reg_req_in.wdata[5:4] != 2'h0 |-> ##2 !integration_gate_out)
        else $error("gate level outside gate mode");
    drive_low_a: assert property (aux_pin_out == '0)
        else $error("open drain data not low");
    fault_top_a: assert property (reg_req_in.rd && a == 8'h41 |=> reg_rdata_out[7])
        else $error("fault top bit not one");
    stat_top_a: assert property (reg_req_in.rd && a == 8'h40 |=> !reg_rdata_out[7])
        else $error("status top bit not zero");
    cfg_bit0_a: assert property (reg_req_in.rd && a == 8'h33 |=> !reg_rdata_out[0])
        else $error("config bit zero not zero");
    unmapped_a: assert property (reg_req_in.rd && !(a inside {8'h33, 8'h40, 8'h41}) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule : aux_regs_props
bind aux_pin_status_fault_regs aux_regs_props #(.NUM_PINS(NUM_PINS)) u_props (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .aux_pin_out(aux_pin_out),
    .aux_pin_oe_out(aux_pin_oe_out), .integration_gate_out(integration_gate_out));
`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side of the register strobe port
// ==========================================
module host_model (
    input  wire logic                 ref_clk_in,
    input  wire logic [7:0]           rdata_in,
    output var  aux_pin_pkg::reg_req_t req_out
);
    initial req_out = '0;
    // Strobes last one cycle; changes land on falling edges, clear of sampling.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge ref_clk_in);
        req_out.wr = 1'b0;
    endtask : wr
    // Read data is registered at the taking edge, so it is ready one half cycle on.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_in);
        req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge ref_clk_in);
        req_out.rd = 1'b0;
        d = rdata_in;
    endtask : rd
endmodule : host_model
`default_nettype wire

// >>> test/aux_pin_status_fault_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Testbench
// ==========================================
module aux_pin_status_fault_regs_tb;
    logic clk = 1'b0, rstn = 1'b0, gate, busy = 1'b0, wake = 1'b0, wen = 1'b0;
    logic alert = 1'b0, pd = 1'b0;
    aux_pin_pkg::reg_req_t req;
    aux_pin_pkg::overflow_t ovf = '0;
    logic [7:0] rdata;
    logic [2:0] ext = 3'h7, oe, drv;
    wire  [2:0] pin = ext & ~oe; // Pulled up unless either party pulls low.
    int mismatches = 0, check_count = 0;
    aux_pin_status_fault_regs dut (.ref_clk_in(clk), .resetn_in(rstn), .reg_req_in(req),
        .reg_rdata_out(rdata), .aux_pin_in(pin), .aux_pin_out(drv), .aux_pin_oe_out(oe),
        .integration_gate_out(gate), .snapshot_busy_in(busy), .overflow_in(ovf),
        .stuck_bus_wake_in(wake), .wake_on_timeout_in(wen), .alert_generated_in(alert),
        .pin3_pulldown_in(pd));
    host_model host (.ref_clk_in(clk), .rdata_in(rdata), .req_out(req));
    initial forever #2.5 clk = ~clk;
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        host.rd(a, g);
        cmp(g, e);
    endtask : chk
    task automatic t_reset;
        chk(8'h33, 8'h00);
        // Reset leaves pin two as the gate input, pulled high, so bit 5 reads one.
        chk(8'h40, 8'h20);
        chk(8'h41, 8'h80);
        chk(8'h52, 8'h00);
        cmp({5'h0, oe}, 8'h01);
    endtask : t_reset
    task automatic t_out;
        host.wr(8'h33, 8'h12); w(1); cmp({5'h0, oe}, 8'h03);
        host.wr(8'h33, 8'h50); w(1); cmp({5'h0, oe}, 8'h00);
        alert = 1'b1; host.wr(8'h33, 8'h00); w(1); cmp({5'h0, oe}, 8'h05);
        host.wr(8'h33, 8'h04); w(1); cmp({5'h0, oe}, 8'h01);
        pd = 1'b1; w(2); cmp({5'h0, oe}, 8'h05);
        alert = 1'b0; pd = 1'b0;
    endtask : t_out
    task automatic t_inputs;
        host.wr(8'h33, 8'hff); chk(8'h33, 8'hfe);
        w(6); chk(8'h40, 8'h70);
        ext = 3'h0; w(6); chk(8'h40, 8'h00);
        chk(8'h41, 8'hf0);
        host.wr(8'h41, 8'h00); chk(8'h41, 8'h80);
        host.wr(8'h33, 8'ha8); w(6); chk(8'h40, 8'h70);
    endtask : t_inputs
    task automatic t_gate_events;
        host.wr(8'h33, 8'h00); ext = 3'h2; w(6); chk(8'h40, 8'h20);
        cmp({7'h0, gate}, 8'h01);
        host.wr(8'h41, 8'h00); w(4); chk(8'h41, 8'h80);
        busy = 1'b1; ovf = '1; wake = 1'b1; w(6); chk(8'h40, 8'h2f);
        // A still-present overflow re-sets its bit in the very cycle of a clear.
        host.wr(8'h41, 8'h00); chk(8'h41, 8'h87);
        busy = 1'b0; ovf = '0; wake = 1'b0; w(4); chk(8'h41, 8'h87);
        wen = 1'b1; wake = 1'b1; w(1); wake = 1'b0; w(4); chk(8'h41, 8'h8f);
        // Ones written leave their bits alone; zeros clear; reads change nothing.
        host.wr(8'h41, 8'h08); chk(8'h41, 8'h88);
        chk(8'h41, 8'h88);
        host.wr(8'h41, 8'h00); chk(8'h41, 8'h80);
        host.wr(8'h40, 8'hff); chk(8'h40, 8'h20);
        chk(8'h40, 8'h20);
    endtask : t_gate_events
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // The whole run is some 130 cycles; the watchdog allows ample margin.
    initial begin
        #20000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        t_reset();
        t_out();
        t_inputs();
        t_gate_events();
        wrap_up();
    end
endmodule : aux_pin_status_fault_regs_tb
`default_nettype wire
